// >>> inc/ucb_pkg.sv
// ucb_pkg: register map, field layouts, reset values and timing counts of the link and irq/error config bank
// assumes a single 10 MHz core clock; registers are word aligned behind an AXI4-Lite slave
package ucb_pkg;

   localparam int unsigned CLK_HZ = 10000000;

   // register indices, byte address is four times the index
   localparam logic [11:0] LINK_CFG_IDX = 12'h0C3;
   localparam logic [11:0] IRQ_CFG_IDX = 12'h0C4;
   localparam logic [11:0] STATUS_IDX = 12'h0C5;
   localparam logic [11:0] LINK_CFG_ADDR = 12'(LINK_CFG_IDX * 4);
   localparam logic [11:0] IRQ_CFG_ADDR = 12'(IRQ_CFG_IDX * 4);
   localparam logic [11:0] STATUS_ADDR = 12'(STATUS_IDX * 4);

   localparam logic [31:0] LINK_CFG_RST = 32'h1021_6600;
   localparam logic [31:0] IRQ_CFG_RST = 32'h00FF_0000;
   // bits 27, 25 and 11 of the irq/error register hold zero
   localparam logic [31:0] IRQ_CFG_WMASK = 32'hF5FF_F7FF;
   localparam int unsigned POLY_FORCED_BIT = 16;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // fixed crc parameters: the default set used when the configured set is not selected, and the two seed values
   localparam logic [15:0] CRC_DEFAULT_POLY = 16'h1021;
   localparam logic CRC_DEFAULT_REVERSED = 1'h0;
   localparam logic [15:0] CRC_SEED_ZERO = 16'h0000;
   localparam logic [15:0] CRC_SEED_ONES = 16'h1111;

   // link bit rates
   localparam int unsigned BAUD_SLOW = 9600;
   localparam int unsigned BAUD_19200 = 19200;
   localparam int unsigned BAUD_38400 = 38400;
   localparam int unsigned BAUD_57600 = 57600;
   localparam int unsigned BAUD_115200 = 115200;
   localparam logic [10:0] DIV_SLOW = 11'((CLK_HZ + BAUD_SLOW / 2) / BAUD_SLOW);
   localparam logic [10:0] DIV_19200 = 11'((CLK_HZ + BAUD_19200 / 2) / BAUD_19200);
   localparam logic [10:0] DIV_38400 = 11'((CLK_HZ + BAUD_38400 / 2) / BAUD_38400);
   localparam logic [10:0] DIV_57600 = 11'((CLK_HZ + BAUD_57600 / 2) / BAUD_57600);
   localparam logic [10:0] DIV_115200 = 11'((CLK_HZ + BAUD_115200 / 2) / BAUD_115200);

   // housekeeping timer
   localparam int unsigned HOUR_S = 3600;
   localparam logic [39:0] HOUR_CYCLES = 40'(64'(HOUR_S) * 64'(CLK_HZ));
   localparam logic [5:0] HK_HOURS_0 = 6'h01;
   localparam logic [5:0] HK_HOURS_1 = 6'h02;
   localparam logic [5:0] HK_HOURS_2 = 6'h04;
   localparam logic [5:0] HK_HOURS_3 = 6'h06;
   localparam logic [5:0] HK_HOURS_4 = 6'h08;
   localparam logic [5:0] HK_HOURS_5 = 6'h0C;
   localparam logic [5:0] HK_HOURS_6 = 6'h18;
   localparam logic [5:0] HK_HOURS_7 = 6'h30;

   // interrupt event and error source positions
   localparam int unsigned IRQ_BIT_ERROR_FLAG = 7;
   localparam int unsigned IRQ_BIT_BOOT_DONE = 2;
   localparam int unsigned ERR_BIT_UNUSED = 11;

   typedef struct packed {
      logic [15:0] link_crc_polynomial;
      logic link_crc_reversed;
      logic link_crc_seed_select;
      logic link_crc_configured;
      logic wake_command_enable;
      logic [1:0] fast_rate_select;
      logic fast_rate_usage;
      logic remote_irq_clear_select;
      logic [3:0] auto_message_base;
      logic [3:0] auto_message_length;
   } ucb_link_cfg_t;

   typedef struct packed {
      logic post_boot_checksum_enable;
      logic [2:0] housekeeping_timer_period;
      logic zero27;
      logic housekeeping_request_enable;
      logic zero25;
      logic postproc_request_enable;
      logic [7:0] irq_mask;
      logic [15:0] err_mask;
   } ucb_irq_cfg_t;

   typedef struct packed {
      logic [15:0] poly;
      logic reversed;
      logic [15:0] seed;
   } ucb_crc_t;

endpackage

// >>> verilog/ucb_sync2.sv
// ucb_sync2: two flip-flop synchroniser for a vector of independent levels
// assumes each bit is a slow level; no bus coherence across bits
`timescale 1ns/100ps
`default_nettype none
module ucb_sync2 #(
   parameter int unsigned WIDTH = 1
) (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_reg;

   always_ff @(posedge core_clk) begin
      if (srst) begin
         meta_reg <= '0;
         sync_out <= '0;
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end
endmodule
`default_nettype wire

// >>> verilog/ucb_hk_timer.sv
// ucb_hk_timer: housekeeping period timer, one-cycle tick every selected number of hours
// assumes period code is static between ticks; a change takes effect from the next hour
`timescale 1ns/100ps
`default_nettype none
module ucb_hk_timer #(
   parameter logic [39:0] HOUR_CYCLES = ucb_pkg::HOUR_CYCLES
) (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic [2:0] period_code,
   output logic tick
);
   logic [39:0] pre_reg;
   logic [5:0] hour_reg;
   logic [5:0] hours;
   logic hour_end;

   always_comb begin
      case (period_code)
         3'h0: hours = ucb_pkg::HK_HOURS_0;
         3'h1: hours = ucb_pkg::HK_HOURS_1;
         3'h2: hours = ucb_pkg::HK_HOURS_2;
         3'h3: hours = ucb_pkg::HK_HOURS_3;
         3'h4: hours = ucb_pkg::HK_HOURS_4;
         3'h5: hours = ucb_pkg::HK_HOURS_5;
         3'h6: hours = ucb_pkg::HK_HOURS_6;
         default: hours = ucb_pkg::HK_HOURS_7;
      endcase
   end

   assign hour_end = (pre_reg == HOUR_CYCLES - 40'h1);

   always_ff @(posedge core_clk) begin
      if (srst || hour_end) begin
         pre_reg <= '0;
      end else begin
         pre_reg <= pre_reg + 40'h1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         hour_reg <= '0;
         tick <= 1'b0;
      end else begin
         tick <= 1'b0;
         if (hour_end) begin
            if (hour_reg >= hours - 6'h1) begin
               hour_reg <= '0;
               tick <= 1'b1;
            end else begin
               hour_reg <= hour_reg + 6'h1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// >>> verilog/ucb_config_bank.sv
// ucb_config_bank: link config and irq/error enable registers over AXI4-Lite, with the logic they steer
// assumes event inputs come from same-clock logic; error sources are asynchronous levels
// Contract
// RULE1 - hold 16-bit link crc polynomial in 31:16, reset 1021, bit 16 one
// RULE2 - bit 15 picks normal or reversed crc bit order, reset zero
// RULE3 - bit 14 seeds crc with 0000 or 1111, reset one
// RULE4 - bit 13 picks default or configured crc in flow mode, else shadow copy
// RULE5 - bit 12 enables wake command recognition, reset zero
// RULE6 - field 11:10 picks fast rate 19200 to 115200 baud, reset 01
// RULE7 - bit 9 lets the device use the fast rate for its auto message
// RULE8 - bit 8 picks remote clear or automatic clear of the remote interrupt
// RULE9 - field 7:4 gives upper four bits of auto message start address
// RULE10 - field 3:0 gives auto message word count, zero disables it
// RULE11 - bit 31 enables a checksum run after boot completes, reset zero
// RULE12 - field 30:28 picks housekeeping timer period from 1h to 48h
// RULE13 - bit 26 enables the housekeeping cpu request from that timer
// RULE14 - software setting bit 24 must also set post processing enable elsewhere
// RULE15 - bits 23:16 enable eight interrupt request sources, all reset one
// RULE16 - bits 15:12 let four memory checksum errors raise the error flag
// RULE17 - bits 10:7 let eeprom and sequence timeouts raise the error flag
// RULE18 - bits 6:0 let measurement faults raise the error flag, reset zero
// RULE19 - error flag routed to a pin drives that pin low while active
// RULE20 - error flag is high while any enabled error source is active
// RULE21 - remote interrupt is raised only by enabled event sources
`timescale 1ns/100ps
`default_nettype none
module ucb_config_bank #(
   parameter logic [39:0] HOUR_CYCLES = ucb_pkg::HOUR_CYCLES
) (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic flow_meter_mode,
   input wire logic shadow_crc_configured,
   input wire logic wake_cmd_seen,
   input wire logic remote_fast_req,
   input wire logic auto_msg_active,
   input wire logic [6:0] irq_events,
   input wire logic remote_irq_clear,
   input wire logic link_tx_done,
   input wire logic [15:0] err_sources,
   input wire logic err_on_gpio,
   output ucb_pkg::ucb_crc_t crc_cfg,
   output logic wake_detect,
   output logic fast_rate_active,
   output logic baud_tick,
   output logic remote_irq,
   output logic [3:0] auto_message_base,
   output logic [3:0] auto_message_length,
   output logic auto_message_enable,
   output logic checksum_start,
   output logic housekeeping_req,
   output logic postproc_request_enable,
   output logic error_flag,
   output logic err_pin_out,
   output logic err_pin_oe
);
   ucb_pkg::ucb_link_cfg_t link_reg;
   ucb_pkg::ucb_irq_cfg_t irq_reg;
   logic [11:0] awaddr_reg;
   logic aw_held_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;
   logic w_held_reg;
   logic do_write;
   logic [31:0] strb_mask;
   logic [31:0] link_next;
   logic [31:0] irq_next;
   logic [31:0] status_word;
   logic [15:0] err_sync;
   logic [15:0] err_masked;
   logic [7:0] irq_src;
   logic [7:0] irq_pend_reg;
   logic [7:0] irq_pend_next;
   logic irq_clear;
   logic crc_use_cfg;
   logic fast_next;
   logic [10:0] baud_cnt_reg;
   logic [10:0] baud_div;
   logic hk_tick;

   ucb_sync2 #(.WIDTH(16)) u_err_sync (
      .core_clk(core_clk),
      .srst(srst),
      .async_in(err_sources),
      .sync_out(err_sync)
   );

   ucb_hk_timer #(.HOUR_CYCLES(HOUR_CYCLES)) u_hk_timer (
      .core_clk(core_clk),
      .srst(srst),
      .period_code(irq_reg.housekeeping_timer_period), // [RULE12]
      .tick(hk_tick)
   );

   // write channel: address and data taken in either order, response after both
   assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;

   always_ff @(posedge core_clk) begin
      if (srst) begin
         aw_held_reg <= 1'b0;
         awaddr_reg <= '0;
         s_axi_awready <= 1'b0;
      end else begin
         s_axi_awready <= !aw_held_reg && !s_axi_awready && !s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            awaddr_reg <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end else if (do_write) begin
            aw_held_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         w_held_reg <= 1'b0;
         wdata_reg <= '0;
         wstrb_reg <= '0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_wready <= !w_held_reg && !s_axi_wready && !s_axi_bvalid;
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end else if (do_write) begin
            w_held_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= ucb_pkg::RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= (awaddr_reg == ucb_pkg::LINK_CFG_ADDR || awaddr_reg == ucb_pkg::IRQ_CFG_ADDR ||
                         awaddr_reg == ucb_pkg::STATUS_ADDR) ? ucb_pkg::RESP_OKAY : ucb_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   assign strb_mask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}}, {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};

   always_comb begin
      link_next = (link_reg & ~strb_mask) | (wdata_reg & strb_mask);
      link_next[ucb_pkg::POLY_FORCED_BIT] = 1'b1; // [RULE1]
      irq_next = ((irq_reg & ~strb_mask) | (wdata_reg & strb_mask)) & ucb_pkg::IRQ_CFG_WMASK;
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         link_reg <= ucb_pkg::LINK_CFG_RST; // [RULE1] [RULE2] [RULE3] [RULE5] [RULE6] [RULE7] [RULE8] [RULE10]
      end else if (do_write && awaddr_reg == ucb_pkg::LINK_CFG_ADDR) begin
         link_reg <= link_next;
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         irq_reg <= ucb_pkg::IRQ_CFG_RST; // [RULE11] [RULE15] [RULE16] [RULE17] [RULE18]
      end else if (do_write && awaddr_reg == ucb_pkg::IRQ_CFG_ADDR) begin
         irq_reg <= irq_next;
      end
   end

   // read channel
   assign status_word = {20'h0, fast_rate_active, error_flag, remote_irq, 1'b0, irq_pend_reg};

   always_ff @(posedge core_clk) begin
      if (srst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= ucb_pkg::RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= ucb_pkg::RESP_OKAY;
            case (s_axi_araddr)
               ucb_pkg::LINK_CFG_ADDR: s_axi_rdata <= link_reg;
               ucb_pkg::IRQ_CFG_ADDR: s_axi_rdata <= irq_reg;
               ucb_pkg::STATUS_ADDR: s_axi_rdata <= status_word;
               default: begin
                  s_axi_rdata <= '0;
                  s_axi_rresp <= ucb_pkg::RESP_SLVERR;
               end
            endcase
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // link crc selection
   assign crc_use_cfg = flow_meter_mode ? link_reg.link_crc_configured : shadow_crc_configured; // [RULE4]

   always_ff @(posedge core_clk) begin
      if (srst) begin
         crc_cfg <= '0;
      end else if (crc_use_cfg) begin
         crc_cfg.poly <= link_reg.link_crc_polynomial; // [RULE1]
         crc_cfg.reversed <= link_reg.link_crc_reversed; // [RULE2]
         crc_cfg.seed <= link_reg.link_crc_seed_select ? ucb_pkg::CRC_SEED_ONES : ucb_pkg::CRC_SEED_ZERO; // [RULE3]
      end else begin
         crc_cfg.poly <= ucb_pkg::CRC_DEFAULT_POLY; // [RULE4]
         crc_cfg.reversed <= ucb_pkg::CRC_DEFAULT_REVERSED;
         crc_cfg.seed <= ucb_pkg::CRC_SEED_ZERO;
      end
   end

   // wake, rate and message outputs
   assign fast_next = remote_fast_req || (link_reg.fast_rate_usage && auto_msg_active); // [RULE7]

   always_comb begin
      if (!fast_rate_active) begin
         baud_div = ucb_pkg::DIV_SLOW;
      end else begin
         case (link_reg.fast_rate_select) // [RULE6]
            2'h0: baud_div = ucb_pkg::DIV_19200;
            2'h1: baud_div = ucb_pkg::DIV_38400;
            2'h2: baud_div = ucb_pkg::DIV_57600;
            default: baud_div = ucb_pkg::DIV_115200;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         baud_cnt_reg <= '0;
         baud_tick <= 1'b0;
      end else if (baud_cnt_reg >= baud_div - 11'h1) begin
         baud_cnt_reg <= '0;
         baud_tick <= 1'b1;
      end else begin
         baud_cnt_reg <= baud_cnt_reg + 11'h1;
         baud_tick <= 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         wake_detect <= 1'b0;
         fast_rate_active <= 1'b0;
         auto_message_base <= '0;
         auto_message_length <= '0;
         auto_message_enable <= 1'b0;
      end else begin
         wake_detect <= wake_cmd_seen && link_reg.wake_command_enable; // [RULE5]
         fast_rate_active <= fast_next; // [RULE7]
         auto_message_base <= link_reg.auto_message_base; // [RULE9]
         auto_message_length <= link_reg.auto_message_length; // [RULE10]
         auto_message_enable <= (link_reg.auto_message_length != 4'h0); // [RULE10]
      end
   end

   // error flag and its pin
   always_comb begin
      err_masked = err_sync & irq_reg.err_mask; // [RULE16] [RULE17] [RULE18]
      err_masked[ucb_pkg::ERR_BIT_UNUSED] = 1'b0;
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         error_flag <= 1'b0;
         err_pin_out <= 1'b1;
         err_pin_oe <= 1'b0;
      end else begin
         error_flag <= |err_masked; // [RULE20]
         err_pin_out <= !(|err_masked); // [RULE19]
         err_pin_oe <= err_on_gpio;
      end
   end

   // remote interrupt: sticky pending bits, set wins over clear
   assign irq_src = {error_flag, irq_events} & irq_reg.irq_mask; // [RULE15] [RULE21]
   assign irq_clear = link_reg.remote_irq_clear_select ? link_tx_done : remote_irq_clear; // [RULE8]
   assign irq_pend_next = (irq_clear ? 8'h00 : irq_pend_reg) | irq_src;

   always_ff @(posedge core_clk) begin
      if (srst) begin
         irq_pend_reg <= '0;
         remote_irq <= 1'b0;
      end else begin
         irq_pend_reg <= irq_pend_next;
         remote_irq <= |irq_pend_next; // [RULE21]
      end
   end

   // cpu requests
   always_ff @(posedge core_clk) begin
      if (srst) begin
         checksum_start <= 1'b0;
         housekeeping_req <= 1'b0;
         postproc_request_enable <= 1'b0;
      end else begin
         checksum_start <= irq_events[ucb_pkg::IRQ_BIT_BOOT_DONE] && irq_reg.post_boot_checksum_enable; // [RULE11]
         housekeeping_req <= hk_tick && irq_reg.housekeeping_request_enable; // [RULE13]
         postproc_request_enable <= irq_reg.postproc_request_enable; // [RULE14]
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);

   poly_bit_one_a: assert property (link_reg.link_crc_polynomial[0]) // [RULE1]
      else $error("polynomial bit 16 cleared");
   reset_values_a: assert property (disable iff (1'b0) srst |=> (link_reg == ucb_pkg::LINK_CFG_RST) && // [RULE15]
      (irq_reg == ucb_pkg::IRQ_CFG_RST))
      else $error("register reset value wrong");
   crc_default_a: assert property (flow_meter_mode && !link_reg.link_crc_configured |=> // [RULE4]
      crc_cfg.poly == 16'h1021 && crc_cfg.seed == 16'h0000 && !crc_cfg.reversed)
      else $error("default crc not applied");
   crc_seed_a: assert property (flow_meter_mode && link_reg.link_crc_configured && link_reg.link_crc_seed_select |=> // [RULE3]
      crc_cfg.seed == 16'h1111)
      else $error("crc seed wrong");
   wake_gate_a: assert property (wake_detect |-> $past(link_reg.wake_command_enable) && $past(wake_cmd_seen)) // [RULE5]
      else $error("wake command passed while disabled");
   fast_rate_a: assert property (!remote_fast_req && !(link_reg.fast_rate_usage && auto_msg_active) |=> // [RULE7]
      !fast_rate_active)
      else $error("fast rate without cause");
   msg_enable_a: assert property (auto_message_enable == (auto_message_length != 4'h0)) // [RULE10]
      else $error("auto message enable mismatch");
   err_mask_a: assert property ((irq_reg.err_mask == 16'h0000) [*3] |-> !error_flag) // [RULE20]
      else $error("error flag with all sources masked");
   err_pin_a: assert property (err_pin_oe && error_flag |-> !err_pin_out) // [RULE19]
      else $error("error pin not low");
   irq_masked_a: assert property (!remote_irq && ((irq_events & irq_reg.irq_mask[6:0]) == 7'h00) && // [RULE21]
      !(error_flag && irq_reg.irq_mask[ucb_pkg::IRQ_BIT_ERROR_FLAG]) |=> !remote_irq)
      else $error("interrupt from masked source");
   hk_gate_a: assert property (housekeeping_req |-> $past(irq_reg.housekeeping_request_enable)) // [RULE13]
      else $error("housekeeping request while disabled");
   resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");

   write_read_c: cover property (s_axi_bvalid && s_axi_bready ##[1:20] s_axi_rvalid && s_axi_rready);
   irq_raise_c: cover property ($rose(remote_irq));
   error_flag_c: cover property ($rose(error_flag) && err_pin_oe);
   fast_rate_c: cover property ($rose(fast_rate_active));
endmodule
`default_nettype wire

// >>> tb/ucb_remote_host.sv
// ucb_remote_host: remote controller model, clears the remote interrupt, asks for fast rate
// assumes the bank's clock; answers one or seven cycles after the interrupt
`timescale 1ns/100ps
`default_nettype none
module ucb_remote_host (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic remote_irq,
   input wire logic clear_by_host,
   input wire logic slow,
   input wire logic fast_want,
   output logic remote_irq_clear,
   output logic remote_fast_req
);
   logic [2:0] wait_reg;
   always_ff @(posedge core_clk) begin
      if (srst) begin
         wait_reg <= 3'h0;
         remote_irq_clear <= 1'h0;
      end else begin
         remote_irq_clear <= 1'h0;
         wait_reg <= 3'h0;
         if (remote_irq && clear_by_host && !remote_irq_clear) begin
            wait_reg <= wait_reg + 3'h1;
            if (wait_reg >= (slow ? 3'h6 : 3'h0)) begin
               remote_irq_clear <= 1'h1;
               wait_reg <= 3'h0;
            end
         end
      end
   end
   always_ff @(posedge core_clk) begin
      remote_fast_req <= srst ? 1'h0 : fast_want;
   end
endmodule
`default_nettype wire

// >>> tb/tb_ucb_config_bank.sv
// tb_ucb_config_bank: axi master, event and error stimulus, queued result checks
// assumes the config bank and the remote host model are compiled beside it
`timescale 1ns/100ps
`default_nettype none
module tb_ucb_config_bank;
   logic core_clk = 1'h0, srst = 1'h1, mode = 1'h1, tx_done = 1'h0, host_clr = 1'h1, slow = 1'h0, fwant = 1'h0;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0, shad = 1'h0, wk = 1'h0;
   logic awready, wready, bvalid, arready, rvalid, rirq, eflag, pin, oe, fast, mclr, freq, aenb, ppe, wdet;
   logic [11:0] awaddr = 12'h0, araddr = 12'h0;
   logic [31:0] wdata = 32'h0, rdata;
   logic [1:0] bresp, rresp;
   logic [6:0] ev = 7'h0;
   logic [15:0] errs = 16'h0;
   logic [3:0] abase, alen;
   ucb_pkg::ucb_crc_t crc;
   logic [31:0] exp_r[$];
   logic [1:0] exp_b[$];
   int n_mismatch = 0, comparisons = 0;
   always #50 core_clk = ~core_clk;
   ucb_config_bank #(.HOUR_CYCLES(40'h14)) i_ucb_config_bank (.core_clk(core_clk), .srst(srst),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .flow_meter_mode(mode), .shadow_crc_configured(shad), .wake_cmd_seen(wk), .remote_fast_req(freq),
      .auto_msg_active(1'h0), .irq_events(ev), .remote_irq_clear(mclr), .link_tx_done(tx_done),
      .err_sources(errs), .err_on_gpio(1'h1), .crc_cfg(crc), .wake_detect(wdet), .fast_rate_active(fast),
      .baud_tick(), .remote_irq(rirq), .auto_message_base(abase), .auto_message_length(alen),
      .auto_message_enable(aenb), .checksum_start(), .housekeeping_req(), .postproc_request_enable(ppe),
      .error_flag(eflag), .err_pin_out(pin), .err_pin_oe(oe));
   ucb_remote_host i_ucb_remote_host (.core_clk(core_clk), .srst(srst), .remote_irq(rirq),
      .clear_by_host(host_clr), .slow(slow), .fast_want(fwant), .remote_irq_clear(mclr), .remote_fast_req(freq));
   task automatic complete_run();
      if (n_mismatch == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      comparisons++;
      if (s !== e) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic tmo(input int n);
      if (n >= 40) begin
         n_mismatch++;
         complete_run();
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
      int n;
      exp_b.push_back(r);
      @(posedge core_clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      for (n = 0; n < 40; n++) begin
         @(posedge core_clk);
         if (awready) awvalid <= 1'h0;
         if (wready) wvalid <= 1'h0;
         if (bvalid) break;
      end
      bready <= 1'h0;
      tmo(n);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      int n;
      exp_r.push_back(e);
      @(posedge core_clk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      for (n = 0; n < 40; n++) begin
         @(posedge core_clk);
         if (arready) arvalid <= 1'h0;
         if (rvalid) break;
      end
      rready <= 1'h0;
      tmo(n);
   endtask
   task automatic evp(input logic [6:0] v);
      ev <= v;
      @(posedge core_clk);
      ev <= 7'h0;
   endtask
   // result watcher: oldest note against each response
   always @(posedge core_clk) begin
      if (bvalid && bready) chk("bresp", 32'(exp_b.pop_front()), 32'(bresp));
      if (rvalid && rready) chk("rdata", exp_r.pop_front(), rdata);
   end
   initial begin
      logic [31:0] d;
      void'($urandom(48));
      cyc(3);
      srst <= 1'h0;
      rd(ucb_pkg::LINK_CFG_ADDR, 32'h1021_6600);
      rd(ucb_pkg::IRQ_CFG_ADDR, 32'h00FF_0000);
      for (int i = 0; i < 4; i++) begin
         d = $urandom;
         d[16] = 1'h0;
         d[14] = i[1];
         d[13] = i[0];
         if (i == 0) d[3:0] = 4'h0;
         d[8] = 1'h0;
         wr(ucb_pkg::LINK_CFG_ADDR, d, 2'h0);
         d[16] = 1'h1;
         rd(ucb_pkg::LINK_CFG_ADDR, d);
         chk("poly", d[13] ? d[31:16] : 16'h1021, crc.poly);
         chk("rev", d[13] & d[15], crc.reversed);
         chk("seed", (d[13] & d[14]) ? 16'h1111 : 16'h0, crc.seed);
         chk("base", d[7:4], abase);
         chk("len", d[3:0], alen);
         chk("msg_en", d[3:0] != 4'h0, aenb);
      end
      wk <= 1'h1;
      cyc(1);
      wk <= 1'h0;
      cyc(1);
      chk("wake", d[12], wdet);
      mode <= 1'h0;
      cyc(3);
      chk("seed_shadow", 16'h0, crc.seed);
      shad <= 1'h1;
      cyc(3);
      chk("seed_shadow_cfg", 16'h1111, crc.seed);
      mode <= 1'h1;
      d = $urandom;
      wr(ucb_pkg::IRQ_CFG_ADDR, d, 2'h0);
      wr(12'h000, 32'hFFFF_FFFF, 2'h2);
      rd(ucb_pkg::IRQ_CFG_ADDR, d & 32'hF5FF_F7FF);
      chk("pp_req", d[24], ppe);
      for (int i = 0; i < 16; i++) begin
         if (i == 11) continue;
         wr(ucb_pkg::IRQ_CFG_ADDR, 32'h1 << i, 2'h0);
         errs <= ~(16'h1 << i);
         cyc(5);
         chk("flag_off", 1'h0, eflag);
         errs <= 16'h1 << i;
         cyc(5);
         chk("flag_on", 1'h1, eflag);
         chk("pin", 2'h1, {pin, oe});
      end
      errs <= 16'h0;
      wr(ucb_pkg::IRQ_CFG_ADDR, 32'h0002_0000, 2'h0);
      evp(7'h01);
      cyc(3);
      chk("irq_masked", 1'h0, rirq);
      for (int s = 0; s < 2; s++) begin
         slow <= s[0];
         evp(7'h02);
         cyc(2);
         chk("irq_set", 1'h1, rirq);
         cyc(12);
         chk("irq_host_clr", 1'h0, rirq);
      end
      host_clr <= 1'h0;
      wr(ucb_pkg::LINK_CFG_ADDR, 32'h1021_6700, 2'h0);
      evp(7'h02);
      cyc(12);
      chk("irq_held", 1'h1, rirq);
      tx_done <= 1'h1;
      cyc(1);
      tx_done <= 1'h0;
      cyc(3);
      chk("irq_auto_clr", 1'h0, rirq);
      fwant <= 1'h1;
      cyc(4);
      chk("fast_on", 1'h1, fast);
      fwant <= 1'h0;
      cyc(4);
      chk("fast_off", 1'h0, fast);
      complete_run();
   end
endmodule
`default_nettype wire
